// ### rtl/tlih_params.svh
// register offsets, field positions, reset values and timing counts of the interrupt handler
`ifndef TLIH_PARAMS_SVH
`define TLIH_PARAMS_SVH

// bus and register geometry
`define TLIH_AW 8
`define TLIH_DATA_W 32
`define TLIH_REG_W 8
`define TLIH_GROUPS 3
`define TLIH_SRC_N 24

// group index inside the packed group vectors
`define TLIH_GRP_LO 0
`define TLIH_GRP_MID 1
`define TLIH_GRP_HI 2

// byte addresses on the apb bus
`define TLIH_OFF_FLAGS_HI 8'h00
`define TLIH_OFF_FLAGS_MID 8'h04
`define TLIH_OFF_FLAGS_LO 8'h08
`define TLIH_OFF_EN_HI 8'h0c
`define TLIH_OFF_EN_MID 8'h10
`define TLIH_OFF_EN_LO 8'h14
`define TLIH_OFF_PRIO 8'h18
`define TLIH_OFF_SUMM 8'h1c

// level summary bit positions
`define TLIH_SUMM_LO_BIT 0
`define TLIH_SUMM_MID_BIT 1
`define TLIH_SUMM_HI_BIT 2

// reset values
`define TLIH_RST_FLAGS 8'h00
`define TLIH_RST_EN 8'h00
`define TLIH_RST_PRIO 8'hff
`define TLIH_RST_SUMM 8'h00
`define TLIH_NO_PEND 8'hff

// clock cycles from source rising edge to core interrupt rising edge
`define TLIH_CORE_LAT 1

`endif

// ### rtl/tlih_pkg.sv
// types shared by the interrupt handler modules
`include "tlih_params.svh"

package tlih_pkg;

    typedef logic [`TLIH_REG_W-1:0] tlih_byte_t;
    typedef logic [`TLIH_GROUPS-1:0][`TLIH_REG_W-1:0] tlih_grp_vec_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`TLIH_AW-1:0] paddr;
        logic [`TLIH_DATA_W-1:0] pwdata;
    } tlih_apb_req_t;

    typedef struct packed {
        tlih_grp_vec_t enables;
        tlih_byte_t top_code;
        tlih_byte_t summary;
        logic [`TLIH_GROUPS-1:0] core_int;
        logic [`TLIH_DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
    } tlih_top_st_t;

endpackage : tlih_pkg

// ### rtl/tlih_flag_bank.sv
// edge-detecting, write-one-to-clear flag bank for one priority group
`timescale 1ns/1ps
`include "tlih_params.svh"

module tlih_flag_bank #(
    parameter int W = `TLIH_REG_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] src,
    input wire logic [W-1:0] enable,
    input wire logic [W-1:0] clear,
    output logic [W-1:0] flags,
    output logic [W-1:0] flags_nxt,
    output logic [W-1:0] set_now
);
    import tlih_pkg::*;

    typedef struct packed {
        logic [W-1:0] src_d;
        logic [W-1:0] flags;
    } tlih_bank_st_t;

    tlih_bank_st_t st_r;
    tlih_bank_st_t st_nxt;

    always_comb begin
        st_nxt.src_d = src; // R10
        set_now = src & ~st_r.src_d & enable; // R4
        // a set arriving together with its clear wins
        st_nxt.flags = (st_r.flags & ~clear) | set_now; // R5
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0; // R6
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flags;
    assign flags_nxt = st_nxt.flags;

endmodule : tlih_flag_bank

// ### rtl/tlih_prio_enc.sv
// highest-index priority encoder over all pending flags
`timescale 1ns/1ps
`include "tlih_params.svh"

module tlih_prio_enc #(
    parameter int N = `TLIH_SRC_N,
    parameter int CW = `TLIH_REG_W
) (
    input wire logic [N-1:0] flags,
    output logic [CW-1:0] code
);
    import tlih_pkg::*;

    always_comb begin
        code = CW'(`TLIH_NO_PEND); // R8
        // later hits overwrite earlier ones, so the highest index wins
        for (int i = 0; i < N; i++) begin
            if (flags[i]) begin
                code = CW'(i); // R15
            end
        end
    end

endmodule : tlih_prio_enc

// ### rtl/tlih_top.sv
// three-level interrupt handler with its apb register slave
`timescale 1ns/1ps
`include "tlih_params.svh"

// Notes on behaviour
// R1: there are 24 interrupt sources split into high, mid and low groups of eight.
// R2: the high group drives the first core input, mid the second, low the third.
// R3: flag bits 7..0 are sources 23..16 (high), 15..8 (mid) and 7..0 (low).
// R4: a flag is set only on a rising edge of its source while its enable bit is one.
// R5: a flag stays set until a one is written to it; writing zero leaves it alone.
// R6: reset clears every flag.
// R7: each source has a read-write enable bit at its flag position, one enables, reset zero.
// R8: the priority register returns the code of the highest flag set, 0xff when none, reset 0xff.
// R9: summary bits 2, 1, 0 show any flag set in high, mid, low; bits 7..3 read zero.
// R10: sources are sampled on every edge of the fastest clock and a rising edge is remembered; the banks sample only on the rising edge of pclk.
// R11: the core input rises exactly one clock after the source rises.
// R12: flag, enable, priority and summary registers are eight bits wide.
// R13: the core services the first input before the second and the second before the third.
// R14: software clears both the flag here and the pending bit in the core.
// R15: the priority code names the highest-index pending source, 23 highest and 0 lowest.
// R16: a new flag set in a group gives a fresh rising edge on that group's core input; sets in back-to-back cycles give one longer high and no second edge.
module tlih_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TLIH_AW-1:0] paddr,
    input wire logic [`TLIH_DATA_W-1:0] pwdata,
    output logic [`TLIH_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`TLIH_SRC_N-1:0] irq_src,
    output logic core_int_first,
    output logic core_int_second,
    output logic core_int_third
);
    import tlih_pkg::*;

    tlih_apb_req_t req;
    tlih_top_st_t st_r;
    tlih_top_st_t st_nxt;
    tlih_grp_vec_t flags;
    tlih_grp_vec_t flags_nxt;
    tlih_grp_vec_t set_now;
    tlih_grp_vec_t clr_mask;
    logic [`TLIH_SRC_N-1:0] flags_all_nxt;
    logic [`TLIH_REG_W-1:0] code_nxt;
    logic [`TLIH_REG_W-1:0] wbyte;
    logic setup_ph;
    logic wr_acc;

    assign req = '{
        psel: psel,
        penable: penable,
        pwrite: pwrite,
        paddr: paddr,
        pwdata: pwdata
    };

    assign setup_ph = req.psel & ~req.penable;
    // writes land on the access edge, where pready is already high
    assign wr_acc = req.psel & req.penable & req.pwrite & st_r.ready;
    assign wbyte = req.pwdata[`TLIH_REG_W-1:0];

    // write-one-to-clear strobes for the flag banks
    always_comb begin
        clr_mask = '0;
        if (wr_acc) begin
            case (req.paddr)
                `TLIH_OFF_FLAGS_HI: begin
                    clr_mask[`TLIH_GRP_HI] = wbyte; // R5
                end
                `TLIH_OFF_FLAGS_MID: begin
                    clr_mask[`TLIH_GRP_MID] = wbyte; // R5
                end
                `TLIH_OFF_FLAGS_LO: begin
                    clr_mask[`TLIH_GRP_LO] = wbyte; // R5
                end
                default: begin
                    clr_mask = '0;
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < `TLIH_GROUPS; g++) begin : g_bank
            tlih_flag_bank #(
                .W(`TLIH_REG_W)
            ) u_bank (
                .pclk(pclk),
                .presetn(presetn),
                .src(irq_src[g*`TLIH_REG_W +: `TLIH_REG_W]), // R1 R3
                .enable(st_r.enables[g]),
                .clear(clr_mask[g]),
                .flags(flags[g]),
                .flags_nxt(flags_nxt[g]),
                .set_now(set_now[g])
            );
        end
    endgenerate

    // high group in the top byte keeps source numbers equal to bit indices
    assign flags_all_nxt = flags_nxt; // R3

    tlih_prio_enc #(
        .N(`TLIH_SRC_N),
        .CW(`TLIH_REG_W)
    ) u_enc (
        .flags(flags_all_nxt),
        .code(code_nxt)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = setup_ph;
        st_nxt.slverr = 1'b0;

        // read data and error are captured in the setup cycle
        if (setup_ph) begin
            st_nxt.rdata = '0;
            case (req.paddr)
                `TLIH_OFF_FLAGS_HI: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = flags[`TLIH_GRP_HI]; // R12
                end
                `TLIH_OFF_FLAGS_MID: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = flags[`TLIH_GRP_MID];
                end
                `TLIH_OFF_FLAGS_LO: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = flags[`TLIH_GRP_LO];
                end
                `TLIH_OFF_EN_HI: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = st_r.enables[`TLIH_GRP_HI]; // R7
                end
                `TLIH_OFF_EN_MID: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = st_r.enables[`TLIH_GRP_MID];
                end
                `TLIH_OFF_EN_LO: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = st_r.enables[`TLIH_GRP_LO];
                end
                `TLIH_OFF_PRIO: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = st_r.top_code; // R8
                    st_nxt.slverr = req.pwrite;
                end
                `TLIH_OFF_SUMM: begin
                    st_nxt.rdata[`TLIH_REG_W-1:0] = st_r.summary; // R9
                    st_nxt.slverr = req.pwrite;
                end
                default: begin
                    st_nxt.slverr = 1'b1;
                end
            endcase
            if (req.pwrite) begin
                st_nxt.rdata = '0;
            end
        end

        if (wr_acc) begin
            case (req.paddr)
                `TLIH_OFF_EN_HI: begin
                    st_nxt.enables[`TLIH_GRP_HI] = wbyte; // R7
                end
                `TLIH_OFF_EN_MID: begin
                    st_nxt.enables[`TLIH_GRP_MID] = wbyte; // R7
                end
                `TLIH_OFF_EN_LO: begin
                    st_nxt.enables[`TLIH_GRP_LO] = wbyte; // R7
                end
                default: begin
                    st_nxt.enables = st_r.enables;
                end
            endcase
        end

        // status follows the flags as they will be after this edge
        st_nxt.top_code = code_nxt; // R8 R15
        st_nxt.summary = `TLIH_RST_SUMM;
        st_nxt.summary[`TLIH_SUMM_HI_BIT] = |flags_nxt[`TLIH_GRP_HI]; // R9
        st_nxt.summary[`TLIH_SUMM_MID_BIT] = |flags_nxt[`TLIH_GRP_MID]; // R9
        st_nxt.summary[`TLIH_SUMM_LO_BIT] = |flags_nxt[`TLIH_GRP_LO]; // R9

        // one-cycle pulse per cycle with an accepted edge gives the core a fresh rising edge; edges in back-to-back cycles merge into one longer pulse
        for (int i = 0; i < `TLIH_GROUPS; i++) begin
            st_nxt.core_int[i] = |set_now[i]; // R11 R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{
                enables: {`TLIH_GROUPS{`TLIH_RST_EN}}, // R7
                top_code: `TLIH_RST_PRIO, // R8
                summary: `TLIH_RST_SUMM,
                core_int: '0,
                rdata: '0,
                ready: 1'b0,
                slverr: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign core_int_first = st_r.core_int[`TLIH_GRP_HI]; // R2
    assign core_int_second = st_r.core_int[`TLIH_GRP_MID]; // R2
    assign core_int_third = st_r.core_int[`TLIH_GRP_LO]; // R2

    // checking logic below
    logic [`TLIH_SRC_N-1:0] src_d_h;
    logic [`TLIH_SRC_N-1:0] rise_en;
    logic [`TLIH_SRC_N-1:0] flags_flat;
    logic [`TLIH_SRC_N-1:0] clr_flat;
    logic [`TLIH_GROUPS-1:0] lvl_rise;
    logic [`TLIH_GROUPS-1:0] core_vec;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_d_h <= '0;
        end else begin
            src_d_h <= irq_src;
        end
    end

    assign flags_flat = flags;
    assign clr_flat = clr_mask;
    assign rise_en = irq_src & ~src_d_h & st_r.enables;
    assign lvl_rise = {|rise_en[23:16], |rise_en[15:8], |rise_en[7:0]};
    assign core_vec = {core_int_first, core_int_second, core_int_third};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    flag_set_a: assert property ( // R4
        rise_en != '0 |=> (flags_flat & $past(rise_en)) == $past(rise_en)
    ) else $error("enabled rising edge did not set its flag");

    flag_cause_a: assert property ( // R4
        (flags_flat & ~$past(flags_flat) & ~$past(rise_en)) == '0
    ) else $error("flag set without an enabled rising edge");

    flag_clear_a: assert property ( // R5
        clr_flat != '0 |=> (flags_flat & $past(clr_flat) & ~$past(rise_en)) == '0
    ) else $error("written one did not clear its flag");

    flag_hold_a: assert property ( // R5
        ($past(flags_flat) & ~flags_flat & ~$past(clr_flat)) == '0
    ) else $error("flag dropped without a one written to it");

    core_latency_a: assert property ( // R11
        lvl_rise != '0 |=> (core_vec & $past(lvl_rise)) == $past(lvl_rise)
    ) else $error("core input did not rise one cycle after its source");

    core_cause_a: assert property ( // R16
        (core_vec & ~$past(lvl_rise)) == '0
    ) else $error("core input high with no new flag in its group");

    prio_code_a: assert property ( // R15
        flags_flat != '0 |-> (st_r.top_code[7:5] == 3'h0)
            && ((flags_flat >> st_r.top_code[4:0]) == `TLIH_SRC_N'(1))
    ) else $error("priority code is not the highest pending source");

    prio_none_a: assert property ( // R8
        flags_flat == '0 |-> st_r.top_code == `TLIH_NO_PEND
    ) else $error("priority code not 0xff with nothing pending");

    level_summary_a: assert property ( // R9
        st_r.summary == {5'h00, |flags[`TLIH_GRP_HI], |flags[`TLIH_GRP_MID],
            |flags[`TLIH_GRP_LO]}
    ) else $error("level summary disagrees with the flags");

    enable_write_a: assert property ( // R7
        wr_acc && req.paddr == `TLIH_OFF_EN_MID
            |=> st_r.enables[`TLIH_GRP_MID] == $past(wbyte)
    ) else $error("enable write did not take the written byte");

    read_width_a: assert property ( // R12
        pready |-> prdata[`TLIH_DATA_W-1:`TLIH_REG_W] == '0
    ) else $error("read data above bit 7 not zero");

    apb_answer_a: assert property ( // R12
        setup_ph |=> pready ##1 !pready
    ) else $error("apb slave did not answer in exactly one access cycle");

    // core inputs echo the enabled edges of their group one cycle later
    route_high_a: assert property ( // R2
        core_int_first == $past(lvl_rise[2])
    ) else $error("first core input does not follow the high group");

    route_mid_a: assert property ( // R2
        core_int_second == $past(lvl_rise[1])
    ) else $error("second core input does not follow the mid group");

    route_low_a: assert property ( // R2
        core_int_third == $past(lvl_rise[0])
    ) else $error("third core input does not follow the low group");

    reset_state_a: assert property ( // R6
        $rose(presetn) |-> flags_flat == '0 && st_r.enables == '0
            && st_r.top_code == `TLIH_RST_PRIO && st_r.summary == `TLIH_RST_SUMM
    ) else $error("registers not at their reset values after reset");

    enable_hold_a: assert property ( // R7
        !wr_acc |=> st_r.enables == $past(st_r.enables)
    ) else $error("enables changed without a write");

    prio_range_a: assert property ( // R15
        st_r.top_code == `TLIH_NO_PEND || st_r.top_code < `TLIH_SRC_N
    ) else $error("priority code outside the source range");

    // flag reads return the group byte as it stood in the setup cycle
    flag_read_hi_a: assert property ( // R3
        setup_ph && !req.pwrite && req.paddr == `TLIH_OFF_FLAGS_HI
            |=> prdata[`TLIH_REG_W-1:0] == $past(flags_flat[23:16])
    ) else $error("high flag read does not show sources 23 to 16");

    flag_read_mid_a: assert property ( // R3
        setup_ph && !req.pwrite && req.paddr == `TLIH_OFF_FLAGS_MID
            |=> prdata[`TLIH_REG_W-1:0] == $past(flags_flat[15:8])
    ) else $error("mid flag read does not show sources 15 to 8");

    flag_read_lo_a: assert property ( // R3
        setup_ph && !req.pwrite && req.paddr == `TLIH_OFF_FLAGS_LO
            |=> prdata[`TLIH_REG_W-1:0] == $past(flags_flat[7:0])
    ) else $error("low flag read does not show sources 7 to 0");

    // refusals: writes to read-only registers and unmapped addresses
    ro_write_err_a: assert property ( // R8
        setup_ph && req.pwrite
            && (req.paddr == `TLIH_OFF_PRIO || req.paddr == `TLIH_OFF_SUMM) |=> pslverr
    ) else $error("write to a read-only register not refused");

    unmapped_err_a: assert property ( // R12
        setup_ph && req.paddr > `TLIH_OFF_SUMM |=> pslverr && prdata == '0
    ) else $error("unmapped address not refused");

    read_ok_a: assert property ( // R12
        setup_ph && !req.pwrite && req.paddr <= `TLIH_OFF_SUMM
            && req.paddr[1:0] == 2'b00 |=> !pslverr
    ) else $error("read of a mapped register refused");

endmodule : tlih_top

// ### sim/tlih_core_model.sv
// behavioural core model: memorises interrupt edges and serves them in level order
`timescale 1ns/1ps

module tlih_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] int_in,
    input wire logic [2:0] clr,
    output logic [2:0] pend,
    output logic [1:0] serve
);
    import tlih_pkg::*;
    logic [2:0] prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 3'h0;
            pend <= 3'h0;
        end else begin
            prev_r <= int_in;
            // software must also clear the pending bit held here
            pend <= (pend | (int_in & ~prev_r)) & ~clr;
        end
    end

    // first input before second, second before third
    always_comb begin
        serve = 2'h3;
        for (int i = 2; i >= 0; i--) begin
            if (pend[i]) begin
                serve = 2'(i);
            end
        end
    end
endmodule : tlih_core_model

// ### sim/tb.sv
// self-checking bench for the three-level interrupt handler
`timescale 1ns/1ps
`include "tlih_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module tb;
    import tlih_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [`TLIH_AW-1:0] paddr;
    logic [`TLIH_DATA_W-1:0] pwdata, prdata, rd;
    logic [`TLIH_SRC_N-1:0] irq_src;
    logic [2:0] cint, clr, pend;
    logic [1:0] serve;
    logic [`TLIH_AW-1:0] flg_a [3];
    logic [`TLIH_AW-1:0] ena_a [3];
    int failures = 0;
    int compares = 0;

    tlih_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_src(irq_src),
        .core_int_first(cint[0]), .core_int_second(cint[1]), .core_int_third(cint[2]));
    tlih_core_model core_m (.pclk(pclk), .presetn(presetn), .int_in(cint), .clr(clr),
        .pend(pend), .serve(serve));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [`TLIH_AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'hff_ff00, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("[ERR] %0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [`TLIH_AW-1:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, {24'h00_0000, e})
        `CHK(err, 1'b0)
    endtask : rchk

    task automatic clr_core(input logic [2:0] v);
        @(posedge pclk);
        clr <= v;
        @(posedge pclk);
        clr <= 3'h0;
        #1;
    endtask : clr_core

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic t_reset();
        for (int g = 0; g < 3; g++) begin
            rchk(flg_a[g], 8'h00);
            rchk(ena_a[g], 8'h00);
        end
        rchk(`TLIH_OFF_PRIO, 8'hff);
        rchk(`TLIH_OFF_SUMM, 8'h00);
        apb(1'b1, 8'h20, 8'hff);
        `CHK(err, 1'b1)
        apb(1'b1, `TLIH_OFF_PRIO, 8'h00);
        `CHK(err, 1'b1)
        rchk(`TLIH_OFF_PRIO, 8'hff);
    endtask : t_reset

    task automatic t_enable();
        for (int g = 0; g < 3; g++) begin
            apb(1'b1, ena_a[g], 8'ha5 ^ 8'(g));
            rchk(ena_a[g], 8'ha5 ^ 8'(g));
            apb(1'b1, ena_a[g], 8'h00);
        end
    endtask : t_enable

    task automatic t_edge();
        int n;
        logic [7:0] m;
        logic [`TLIH_SRC_N-1:0] s;
        for (int g = 0; g < 3; g++) begin
            m = 8'h01 << (2 * g + 1);
            n = 10 * g + 1;
            s = 24'h00_0001 << n;
            @(posedge pclk);
            irq_src <= irq_src | s;
            @(posedge pclk);
            irq_src <= irq_src & ~s;
            rchk(flg_a[g], 8'h00);
            apb(1'b1, ena_a[g], m);
            irq_src <= irq_src | s;
            #1;
            `CHK(cint, 3'h0)
            @(posedge pclk);
            #1;
            `CHK(cint, 3'h4 >> g)
            @(posedge pclk);
            #1;
            `CHK(cint, 3'h0)
            `CHK(pend, 3'h4 >> g)
            rchk(flg_a[g], m);
            rchk(`TLIH_OFF_PRIO, 8'(n));
            rchk(`TLIH_OFF_SUMM, 8'h01 << g);
            apb(1'b1, flg_a[g], ~m);
            rchk(flg_a[g], m);
            apb(1'b1, flg_a[g], m);
            rchk(flg_a[g], 8'h00);
            rchk(`TLIH_OFF_PRIO, 8'hff);
            clr_core(3'h4 >> g);
            `CHK(pend, 3'h0)
            apb(1'b1, ena_a[g], 8'h00);
            irq_src <= irq_src & ~s;
        end
    endtask : t_edge

    task automatic t_prio();
        for (int g = 0; g < 3; g++) begin
            apb(1'b1, ena_a[g], 8'hff);
        end
        irq_src <= 24'h20_1008;
        repeat (3) @(posedge pclk);
        #1;
        `CHK(pend, 3'h7)
        `CHK(serve, 2'h0)
        rchk(`TLIH_OFF_PRIO, 8'h15);
        rchk(`TLIH_OFF_SUMM, 8'h07);
        apb(1'b1, `TLIH_OFF_FLAGS_HI, 8'h20);
        clr_core(3'h1);
        `CHK(serve, 2'h1)
        rchk(`TLIH_OFF_PRIO, 8'h0c);
        apb(1'b1, `TLIH_OFF_FLAGS_MID, 8'h10);
        clr_core(3'h2);
        `CHK(serve, 2'h2)
        rchk(`TLIH_OFF_PRIO, 8'h03);
        rchk(`TLIH_OFF_SUMM, 8'h01);
    endtask : t_prio

    task automatic t_midrun();
        do_reset();
        rchk(`TLIH_OFF_FLAGS_LO, 8'h00);
        rchk(`TLIH_OFF_EN_LO, 8'h00);
        rchk(`TLIH_OFF_PRIO, 8'hff);
        irq_src <= '0;
    endtask : t_midrun

    task automatic results();
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        irq_src = '0;
        clr = 3'h0;
        flg_a = '{`TLIH_OFF_FLAGS_LO, `TLIH_OFF_FLAGS_MID, `TLIH_OFF_FLAGS_HI};
        ena_a = '{`TLIH_OFF_EN_LO, `TLIH_OFF_EN_MID, `TLIH_OFF_EN_HI};
        do_reset();
        t_reset();
        t_enable();
        t_edge();
        t_prio();
        t_midrun();
        results();
    end

    // cuts a hang short well past the expected run length
    initial begin
        #200000;
        failures++;
        results();
    end
endmodule : tb
